// file: logic/pfs_pin_mux.sv
// Purpose: One pin's function decode and output drive
// Assumes: Selector code is already masked for the variant
// Notes: All outputs registered, one cycle behind the code
`timescale 1ns/1ns
`default_nettype none
module pfs_pin_mux import pfs_pkg::*; #(
  parameter pfs_tbl_t TABLE = '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO}
) (
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable
  input wire logic [1:0] code, // Selector field
  input wire logic gpio_o, // Port data out
  input wire logic gpio_oe, // Port direction, high drives
  input wire pfs_periph_t periph, // Peripheral outputs
  output pfs_func_t func, // Selected function
  output logic pad_o, // Pad output level
  output logic pad_oe, // Pad output enable
  output logic analog_en // Pad handed to analog side
);

  pfs_func_t next_func; // Decoded function
  logic next_pad_o; // Drive level
  logic next_pad_oe; // Drive enable
  logic next_analog_en; // Analog path

  // Table lookup, then the driver for that function
  always_comb begin
    next_func = TABLE[code];
    next_pad_o = 1'b0;
    next_pad_oe = 1'b0;
    next_analog_en = 1'b0;
    case (next_func)
      FN_GPIO: begin
        next_pad_o = gpio_o;
        next_pad_oe = gpio_oe;
      end
      FN_TMR0_OUT: begin
        next_pad_o = periph.tmr0_out;
        next_pad_oe = 1'b1;
      end
      FN_TMR1_OUT: begin
        next_pad_o = periph.tmr1_out;
        next_pad_oe = 1'b1;
      end
      FN_TX: begin
        next_pad_o = periph.tx;
        next_pad_oe = 1'b1;
      end
      FN_SDO: begin
        next_pad_o = periph.serial_data_out;
        next_pad_oe = 1'b1;
      end
      FN_C1_OUT: begin
        next_pad_o = periph.c1_out;
        next_pad_oe = 1'b1;
      end
      FN_SCK_SCL: begin
        next_pad_o = periph.sck_o;
        next_pad_oe = periph.sck_oe;
      end
      FN_SERIAL_DATA_IN_OR_TWOWIRE_DATA: begin
        next_pad_o = periph.sda_o;
        next_pad_oe = periph.sda_oe;
      end
      FN_SCS_N: begin
        next_pad_o = periph.scs_n_o;
        next_pad_oe = periph.scs_oe;
      end
      FN_CLK_OUT: begin
        // Stopped clock parks the pin high
        next_pad_o = periph.sysclk_run ? periph.sysclk_out : 1'b1;
        next_pad_oe = 1'b1;
      end
      FN_RX: begin
        next_pad_oe = 1'b0; // Input only
      end
      // Analog, crystal, oscillator, LCD and amplifier pins
      FN_AN3, FN_AN4, FN_AN6, FN_AN7, FN_XT1, FN_XT2, FN_OSCILLATOR_TERMINAL_ONE, FN_OSCILLATOR_TERMINAL_TWO,
      FN_COM1, FN_COM2, FN_AMP0_OUT: begin
        next_analog_en = 1'b1;
      end
      default: begin
        next_pad_oe = 1'b0;
      end
    endcase
  end

  // Output flops, frozen while ce is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      func <= FN_GPIO;
      pad_o <= 1'b0;
      pad_oe <= 1'b0;
      analog_en <= 1'b0;
    end else if (ce) begin
      func <= next_func;
      pad_o <= next_pad_o;
      pad_oe <= next_pad_oe;
      analog_en <= next_analog_en;
    end
  end

endmodule
`default_nettype wire

// file: logic/pfs_pin_select.sv
// Purpose: Port B/C lower pin function selectors with register access
// Assumes: Avalon-MM slave, 50 MHz clock, async active-high reset
// Notes: Variant is fixed at build time; absent fields read zero
`timescale 1ns/1ns
`default_nettype none
module pfs_pin_select import pfs_pkg::*; #(
  parameter pfs_variant_t VARIANT = VAR_MID // Device variant
) (
  input wire logic clock, // System clock, 50 MHz
  input wire logic rst, // Async reset, active high
  input wire logic ce, // Clock enable, freezes all state
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data, registered
  output logic avs_waitrequest, // Stall, combinational
  input wire logic [NUM_PINS-1:0] gpio_o, // Port data per pin
  input wire logic [NUM_PINS-1:0] gpio_oe, // Port direction per pin
  input wire pfs_periph_t periph, // Peripheral outputs
  output logic [NUM_PINS-1:0] pad_o, // Pad level
  output logic [NUM_PINS-1:0] pad_oe, // Pad enable, high drives
  output logic [NUM_PINS-1:0] analog_en, // Pad on analog path
  output pfs_func_t [NUM_PINS-1:0] pin_func // Function per pin
);

  // Implemented-bit masks for this variant
  localparam logic [7:0] PB_HIGH_MASK =
    (VARIANT == VAR_SMALL) ? MASK_PB_HIGH_SMALL : MASK_PB_HIGH_LARGE;
  localparam logic [7:0] PC_LOW_MASK =
    (VARIANT == VAR_SMALL) ? MASK_PC_LOW_SMALL : MASK_PC_LOW_MID;

  // Code-to-function table of one pin on this variant
  function automatic pfs_tbl_t pin_table(input int pin);
    pfs_tbl_t t;
    // Patterns, not concatenations, so each entry stays an enum value
    t = '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO};
    case (pin)
      PIN_PB0: begin
        t = '{FN_XT1, FN_AN3, FN_TMR0_OUT, FN_GPIO};
      end
      PIN_PB1: begin
        t = '{FN_XT2, FN_GPIO, FN_AN4, FN_GPIO};
      end
      PIN_PB2: begin
        // Code 11 left as gpio with timer clock input
        t = '{FN_GPIO, FN_TX, FN_AN6, FN_GPIO};
      end
      PIN_PB4: begin
        t = '{FN_GPIO, FN_AMP0_OUT, FN_CLK_OUT, FN_GPIO};
      end
      PIN_PB5: begin
        t = '{FN_AN7, FN_TX, FN_COM2, FN_GPIO};
      end
      PIN_PB6: begin
        t = '{FN_RX, FN_SERIAL_DATA_IN_OR_TWOWIRE_DATA, FN_COM1, FN_GPIO};
      end
      PIN_PC0: begin
        t = '{FN_GPIO, FN_OSCILLATOR_TERMINAL_ONE, FN_SCS_N, FN_GPIO};
      end
      PIN_PC1: begin
        t = '{FN_GPIO, FN_OSCILLATOR_TERMINAL_TWO, FN_SDO, FN_GPIO};
      end
      PIN_PC2: begin
        if (VARIANT == VAR_SMALL) begin
          t = '{FN_GPIO, FN_GPIO, FN_SCK_SCL, FN_GPIO};
        end else begin
          t = '{FN_GPIO, FN_GPIO, FN_TMR1_OUT, FN_GPIO};
        end
      end
      PIN_PC3: begin
        t = '{FN_C1_OUT, FN_SDO, FN_GPIO, FN_GPIO};
      end
      default: begin
        t = '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO};
      end
    endcase
    return t;
  endfunction

  logic [7:0] pb_low_sel; // Port B low selector register
  logic [7:0] pb_high_sel; // Port B high selector register
  logic [7:0] pc_low_sel; // Port C low selector register
  logic ack; // Answer phase of a bus access
  logic req; // Any access pending
  logic accept; // Access completes this edge
  logic wr_lane0; // Write touching the data byte
  logic [7:0] next_rdata; // Read mux
  logic [23:0] all_sel; // All fields side by side

  // Bus handshake: one wait cycle, then completion
  assign req = avs_read | avs_write;
  assign accept = req & ack & ce;
  assign avs_waitrequest = req & ~(ack & ce);
  assign wr_lane0 = avs_write & accept & avs_byteenable[0];

  // Answer-phase flag, clears on the completing edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= req & ~ack;
    end
  end

  // Port B low selector, all bits live
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pb_low_sel <= RST_SEL;
    end else if (ce && wr_lane0 && avs_address == OFS_PB_LOW) begin
      pb_low_sel <= avs_writedata[7:0] & MASK_PB_LOW;
    end
  end

  // Port B high selector; absent bits never store
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pb_high_sel <= RST_SEL;
    end else if (ce && wr_lane0 && avs_address == OFS_PB_HIGH) begin
      pb_high_sel <= avs_writedata[7:0] & PB_HIGH_MASK;
    end
  end

  // Port C low selector; small variant lacks bits 7:6
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pc_low_sel <= RST_SEL;
    end else if (ce && wr_lane0 && avs_address == OFS_PC_LOW) begin
      pc_low_sel <= avs_writedata[7:0] & PC_LOW_MASK;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (avs_address)
      OFS_PB_LOW: begin
        next_rdata = pb_low_sel;
      end
      OFS_PB_HIGH: begin
        next_rdata = pb_high_sel & PB_HIGH_MASK;
      end
      OFS_PC_LOW: begin
        next_rdata = pc_low_sel & PC_LOW_MASK;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data captured as the wait cycle ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && !ack) begin
      avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  // Fields feeding the pin decoders
  assign all_sel = {pc_low_sel, pb_high_sel, pb_low_sel};

  // One decoder per pin, table chosen by variant
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pfs_pin_mux #(
      .TABLE(pin_table(p))
    ) u_mux (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .code(all_sel[SEL_LSB[p] +: 2]),
      .gpio_o(gpio_o[p]),
      .gpio_oe(gpio_oe[p]),
      .periph(periph),
      .func(pin_func[p]),
      .pad_o(pad_o[p]),
      .pad_oe(pad_oe[p]),
      .analog_en(analog_en[p])
    );
  end

endmodule
`default_nettype wire

// file: logic/pfs_pkg.sv
// Purpose: Shared constants and types for the pin function select block
// Assumes: One 50 MHz system clock, Avalon-MM register access
// Notes: Register offsets are byte addresses of aligned 32-bit words
package pfs_pkg;

  // Pin order used on every per-pin vector
  localparam int NUM_PINS = 10;
  localparam int PIN_PB0 = 0;
  localparam int PIN_PB1 = 1;
  localparam int PIN_PB2 = 2;
  localparam int PIN_PB4 = 3;
  localparam int PIN_PB5 = 4;
  localparam int PIN_PB6 = 5;
  localparam int PIN_PC0 = 6;
  localparam int PIN_PC1 = 7;
  localparam int PIN_PC2 = 8;
  localparam int PIN_PC3 = 9;

  // Field position of each pin inside {pc_low, pb_high, pb_low}
  localparam int SEL_LSB [NUM_PINS] = '{0, 2, 4, 8, 10, 12, 16, 18, 20, 22};

  // Register byte offsets
  localparam logic [3:0] OFS_PB_LOW = 4'h0;
  localparam logic [3:0] OFS_PB_HIGH = 4'h4;
  localparam logic [3:0] OFS_PC_LOW = 4'h8;

  // Values after reset
  localparam logic [7:0] RST_SEL = 8'h00;

  // Implemented bits per register and variant
  localparam logic [7:0] MASK_PB_LOW = 8'hff;
  localparam logic [7:0] MASK_PB_HIGH_SMALL = 8'h03;
  localparam logic [7:0] MASK_PB_HIGH_LARGE = 8'h3f;
  localparam logic [7:0] MASK_PC_LOW_SMALL = 8'h3f;
  localparam logic [7:0] MASK_PC_LOW_MID = 8'hff;

  // Device variants
  typedef enum logic [1:0] {
    VAR_SMALL = 2'h0,
    VAR_MID = 2'h1,
    VAR_LARGE = 2'h2
  } pfs_variant_t;

  // Function that a pin carries
  typedef enum logic [4:0] {
    FN_GPIO = 5'h00, FN_TMR0_OUT = 5'h01, FN_AN3 = 5'h02,
    FN_XT1 = 5'h03, FN_AN4 = 5'h04, FN_XT2 = 5'h05,
    FN_AN6 = 5'h06, FN_TX = 5'h07, FN_CLK_OUT = 5'h08,
    FN_AMP0_OUT = 5'h09, FN_COM2 = 5'h0a, FN_AN7 = 5'h0b,
    FN_COM1 = 5'h0c, FN_SERIAL_DATA_IN_OR_TWOWIRE_DATA = 5'h0d, FN_RX = 5'h0e,
    FN_SCK_SCL = 5'h0f, FN_SDO = 5'h10, FN_OSCILLATOR_TERMINAL_TWO = 5'h11,
    FN_SCS_N = 5'h12, FN_OSCILLATOR_TERMINAL_ONE = 5'h13, FN_C1_OUT = 5'h14,
    FN_TMR1_OUT = 5'h15
  } pfs_func_t;

  // Code-to-function table, entry n for selector code n
  typedef pfs_func_t [3:0] pfs_tbl_t;

  // Digital outputs of the peripherals sharing the pins
  typedef struct packed {
    logic tmr0_out;
    logic tmr1_out;
    logic tx;
    logic serial_data_out;
    logic sck_o;
    logic sck_oe;
    logic sda_o;
    logic sda_oe;
    logic scs_n_o;
    logic scs_oe;
    logic c1_out;
    logic sysclk_out;
    logic sysclk_run;
  } pfs_periph_t;

endpackage

// file: verif/pfs_periph_model.sv
// Purpose: Stand-in for the peripherals that share the pins
// Assumes: One system clock, async active-high reset
// Notes: A stopped system clock parks low, so a forced high shows
`timescale 1ns/1ns
`default_nettype none
module pfs_periph_model import pfs_pkg::*; (
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic run, // System clock running
  output var pfs_periph_t periph // Peripheral outputs
);
  logic [3:0] cnt; // Pattern that changes every cycle
  // Pattern counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  // Low park while stopped, never the last value
  assign periph = {cnt, ~cnt, cnt[2:0], run & cnt[0], run};
endmodule
`default_nettype wire

// file: verif/pfs_pin_select_asserts.sv
// Purpose: Timing properties of selector writes and pin outputs
// Assumes: Pins settle two edges after a completed write
// Notes: Bound into every instance of the top module
`timescale 1ns/1ns
`default_nettype none
module pfs_pin_select_asserts import pfs_pkg::*; #(
  parameter pfs_variant_t VARIANT = VAR_MID // Variant under test
) (
  input wire logic clock, // System clock
  input wire logic rst, // Async reset
  input wire logic ce, // Clock enable
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire pfs_periph_t periph, // Peripheral outputs
  input wire logic [NUM_PINS-1:0] pad_o, // Pad level
  input wire pfs_func_t [NUM_PINS-1:0] pin_func // Function per pin
);
  logic wr_ok; // Write that lands in a register
  logic big; // Variant with the wider tables
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0] && ce;
  assign big = VARIANT != VAR_SMALL;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_pb0_analog: assert property (wr_ok && avs_address == OFS_PB_LOW
    && avs_writedata[1:0] == 2'h2 |-> ##2 pin_func[PIN_PB0] == FN_AN3)
    else $error("pb0 code 2 not analog");
  a_pb4_clkout: assert property (wr_ok && avs_address == OFS_PB_HIGH
    && avs_writedata[1:0] == 2'h1 |-> ##2 pin_func[PIN_PB4] == FN_CLK_OUT)
    else $error("pb4 code 1 not clock out");
  a_clk_stop_high: assert property (pin_func[PIN_PB4] == FN_CLK_OUT
    && $past(ce) |-> pad_o[PIN_PB4] == ($past(periph.sysclk_run) ?
    $past(periph.sysclk_out) : 1'b1)) else $error("clock out level wrong");
  a_pb5_analog: assert property (big && wr_ok && avs_address == OFS_PB_HIGH
    && avs_writedata[3:2] == 2'h3 |-> ##2 pin_func[PIN_PB5] == FN_AN7)
    else $error("pb5 code 3 not analog");
  a_top_bits_zero: assert property (big && avs_read && !avs_waitrequest
    && avs_address == OFS_PB_HIGH |-> avs_readdata[7:6] == 2'h0)
    else $error("pb high bits 7:6 not zero");
  a_pc3_comp: assert property (big && wr_ok && avs_address == OFS_PC_LOW
    && avs_writedata[7:6] == 2'h3 |-> ##2 pin_func[PIN_PC3] == FN_C1_OUT)
    else $error("pc3 code 3 not comparator");
  a_pc2_timer: assert property (big && wr_ok && avs_address == OFS_PC_LOW
    && avs_writedata[5:4] == 2'h1 |-> ##2 pin_func[PIN_PC2] == FN_TMR1_OUT)
    else $error("pc2 code 1 not timer out");
  a_reset_gpio: assert property ($fell(rst)
    |-> pin_func == {NUM_PINS{FN_GPIO}}) else $error("pins not gpio at reset");
endmodule
bind pfs_pin_select pfs_pin_select_asserts #(.VARIANT(VARIANT))
  pfs_pin_select_asserts_inst (.clock(clock), .rst(rst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .periph(periph), .pad_o(pad_o), .pin_func(pin_func));
`default_nettype wire

// file: verif/tb.sv
// Purpose: Register and pin-function tests for the pin select block
// Assumes: Middle variant, clock enable dropped once to freeze the pins
// Notes: Each code goes to every field, one register at a time, then all pins are checked
`timescale 1ns/1ns
`default_nettype none
module tb import pfs_pkg::*; ;
  logic clock, rst, run, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, got;
  logic [NUM_PINS-1:0] gpio_o, gpio_oe, pad_o, pad_oe, analog_en;
  logic ce; // Clock enable of the block
  logic lvl; // Clock level handed to the pin one edge earlier
  logic an; // Expected analog hand-off of one pin
  pfs_periph_t periph;
  pfs_func_t [NUM_PINS-1:0] pin_func;
  int n_errors, checks_done;
  logic [7:0] msk [3] = '{8'hff, 8'h3f, 8'hff}; // Implemented bits
  // Expected function per pin index and code
  pfs_func_t exp_fn [NUM_PINS][4] = '{
    '{FN_GPIO, FN_TMR0_OUT, FN_AN3, FN_XT1},
    '{FN_GPIO, FN_AN4, FN_GPIO, FN_XT2},
    '{FN_GPIO, FN_AN6, FN_TX, FN_GPIO},
    '{FN_GPIO, FN_CLK_OUT, FN_AMP0_OUT, FN_GPIO},
    '{FN_GPIO, FN_COM2, FN_TX, FN_AN7},
    '{FN_GPIO, FN_COM1, FN_SERIAL_DATA_IN_OR_TWOWIRE_DATA, FN_RX},
    '{FN_GPIO, FN_SCS_N, FN_OSCILLATOR_TERMINAL_ONE, FN_GPIO},
    '{FN_GPIO, FN_SDO, FN_OSCILLATOR_TERMINAL_TWO, FN_GPIO},
    '{FN_GPIO, FN_TMR1_OUT, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_GPIO, FN_SDO, FN_C1_OUT}};
  pfs_pin_select #(.VARIANT(VAR_MID)) pfs_pin_select_inst (.clock(clock),
    .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .periph(periph), .pad_o(pad_o), .pad_oe(pad_oe),
    .analog_en(analog_en), .pin_func(pin_func));
  pfs_periph_model pfs_periph_model_inst (.clock(clock), .rst(rst),
    .run(run), .periph(periph));
  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Value compare
  task automatic chk(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // Pin function compare
  task automatic chk_fn(input int p, input pfs_func_t e);
    checks_done++;
    if (pin_func[p] !== e) begin
      n_errors++;
      $display("unexpected pin %0d: expected %s seen %h", p, e.name(),
               pin_func[p]);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic be);
    int i;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'h0, be};
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && i < 20) begin
      @(posedge clock);
      i++;
    end
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      results();
    end else begin
      // Completing edge: read data taken here, request dropped after it
      got = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
    end
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    run = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    gpio_o = 10'h2a5;
    gpio_oe = 10'h0f3;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int r = 0; r < 3; r++) begin
      bus(1'b0, 4'(r * 4), 8'h00, 1'b1);
      chk("reset value", 32'h0, got);
    end
    chk("gpio drive", {12'h0, gpio_oe, gpio_o}, {12'h0, pad_oe, pad_o});
    $display("reset test done");
    // Clock enable low freezes the pins, release lets them follow
    ce <= 1'b0;
    gpio_o <= 10'h15a;
    repeat (3) @(posedge clock);
    chk("frozen pins", 32'h2a5, {22'h0, pad_o});
    ce <= 1'b1;
    repeat (2) @(posedge clock);
    chk("released pins", 32'h15a, {22'h0, pad_o});
    $display("clock enable test done");
    // Refused writes leave the Port B low register clear; the unmapped offset reads zero
    bus(1'b1, 4'hc, 8'h55, 1'b1);
    bus(1'b0, 4'hc, 8'h00, 1'b1);
    chk("unmapped read", 32'h0, got);
    bus(1'b1, OFS_PB_LOW, 8'h55, 1'b0);
    bus(1'b0, OFS_PB_LOW, 8'h00, 1'b1);
    chk("lane off write", 32'h0, got);
    $display("refusal test done");
    // Every code on every field
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 3; r++) begin
        bus(1'b1, 4'(r * 4), {4{2'(c)}}, 1'b1);
        bus(1'b0, 4'(r * 4), 8'h00, 1'b1);
        chk("select readback", {24'h0, {4{2'(c)}} & msk[r]}, got);
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        chk_fn(p, exp_fn[p][c]);
        // Analog, crystal, oscillator, LCD and amplifier pins hand off
        an = exp_fn[p][c] inside {FN_AN3, FN_AN4, FN_AN6, FN_AN7, FN_XT1,
          FN_XT2, FN_OSCILLATOR_TERMINAL_ONE, FN_OSCILLATOR_TERMINAL_TWO, FN_COM1, FN_COM2, FN_AMP0_OUT};
        chk("analog path", {31'h0, an}, {31'h0, analog_en[p]});
      end
    end
    $display("table test done");
    // Clock out with the system clock stopped, then running
    bus(1'b1, OFS_PB_HIGH, 8'h01, 1'b1);
    @(posedge clock);
    chk("stopped clock out", 32'h1, {31'h0, pad_o[PIN_PB4]});
    run <= 1'b1;
    @(posedge clock);
    // Running clock reaches the pin one edge late
    for (int k = 0; k < 4; k++) begin
      lvl = periph.sysclk_out;
      @(posedge clock);
      chk("running clock out", {31'h0, lvl}, {31'h0, pad_o[PIN_PB4]});
    end
    $display("clock out test done");
    results();
  end
endmodule
`default_nettype wire
